// File: rlsc_pkg.sv
package rlsc_pkg;
  // Capability register offsets
  localparam logic [1:0] OFS_CONFIG_REVISION   = 2'h0;
  localparam logic [1:0] OFS_PEAK_LANE_RATE    = 2'h1;
  localparam logic [1:0] OFS_PEAK_LANES        = 2'h2;
  localparam logic [1:0] OFS_SPREAD_CAPABILITY = 2'h3;
  // Field layouts
  localparam int REV_MINOR_LSB   = 0;
  localparam int REV_MAJOR_LSB   = 4;
  localparam int RATE_FIELD_W    = 5;
  localparam int LANES_FIELD_W   = 4;
  localparam int SPREAD_FIELD_W  = 1;
  // Local capability defaults
  localparam logic [7:0] REV_1_0         = 8'h10;
  localparam logic [4:0] RATE_LOW        = 5'h06;
  localparam logic [4:0] RATE_HIGH       = 5'h0A;
  localparam logic [3:0] LANES_ONE       = 4'h1;
  localparam logic [3:0] LANES_TWO       = 4'h2;
  localparam logic [3:0] LANES_FOUR      = 4'h4;
  // Vertical blank ID byte flag positions
  localparam int VBID_VBLANK_BIT  = 0;
  localparam int VBID_SILENCE_BIT = 2;
  localparam int VBID_NOVIDEO_BIT = 3;
  // Idle pattern timing
  localparam int IDLE_PERIOD_CYC  = 8192;
  localparam int IDLE_REPEAT_MIN  = 5;
  localparam int IDLE_SLACK_CYC   = 256;
  // Hot plug detect low pulse, in ns and in clock cycles
  localparam int CLK_PERIOD_NS    = 40;
  localparam int HPD_LOW_MIN_NS   = 500000;
  localparam int HPD_LOW_MAX_NS   = 1000000;
  localparam int HPD_LOW_TGT_NS   = 750000;
  localparam int HPD_LOW_CYC      = (HPD_LOW_TGT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HPD_MIN_CYC      = (HPD_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HPD_MAX_CYC      = HPD_LOW_MAX_NS / CLK_PERIOD_NS;
endpackage : rlsc_pkg

// File: rlsc_cap_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rlsc_cap_if;
  logic [7:0] revision;
  logic [4:0] rate;
  logic [3:0] lanes;
  logic       spread;
  modport src (output revision, output rate, output lanes, output spread);
  modport dst (input revision, input rate, input lanes, input spread);
endinterface : rlsc_cap_if
`default_nettype wire

// File: rlsc_cap_merge.sv
`timescale 1ns/10ps
`default_nettype none
// Keeps the reported capabilities at the lowest common value
module rlsc_cap_merge
  import rlsc_pkg::*;
#(
  parameter logic [7:0] LOCAL_REV    = 8'h10,
  parameter logic [4:0] LOCAL_RATE   = 5'h0A,
  parameter logic [3:0] LOCAL_LANES  = 4'h4,
  parameter logic       LOCAL_SPREAD = 1'b1
) (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       refresh_i,
  input  wire logic       ds_present_i,
  input  wire logic [7:0] ds_rev_i,
  input  wire logic [7:0] ds_rate_i,
  input  wire logic [7:0] ds_lanes_i,
  input  wire logic [7:0] ds_spread_i,
  rlsc_cap_if.src         cap
);
  function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction : min8

  // Reserved rates and lane counts fall back to the nearest lower valid value, or to the lowest valid value if none is lower
  function automatic logic [4:0] legal_rate(input logic [4:0] r);
    legal_rate = (r >= RATE_HIGH) ? RATE_HIGH : RATE_LOW;
  endfunction : legal_rate

  function automatic logic [3:0] legal_lanes(input logic [3:0] n);
    legal_lanes = (n >= LANES_FOUR) ? LANES_FOUR : ((n >= LANES_TWO) ? LANES_TWO : LANES_ONE);
  endfunction : legal_lanes

  wire logic [7:0] next_rev    = ds_present_i ? min8(LOCAL_REV, ds_rev_i) : LOCAL_REV;
  wire logic [4:0] ds_rate_ok  = legal_rate(ds_rate_i[RATE_FIELD_W-1:0]);
  wire logic [3:0] ds_lanes_ok = legal_lanes(ds_lanes_i[LANES_FIELD_W-1:0]);
  wire logic [4:0] next_rate   = ds_present_i ? (ds_rate_ok < LOCAL_RATE ? ds_rate_ok : LOCAL_RATE)
                                              : LOCAL_RATE;
  wire logic [3:0] next_lanes  = ds_present_i ? (ds_lanes_ok < LOCAL_LANES ? ds_lanes_ok : LOCAL_LANES)
                                              : LOCAL_LANES;
  wire logic       next_spread = ds_present_i ? (LOCAL_SPREAD & ds_spread_i[0]) : LOCAL_SPREAD;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cap.revision <= LOCAL_REV;
      cap.rate     <= LOCAL_RATE;
      cap.lanes    <= LOCAL_LANES;
      cap.spread   <= LOCAL_SPREAD;
    end else if (refresh_i) begin
      cap.revision <= next_rev;
      cap.rate     <= next_rate;
      cap.lanes    <= next_lanes;
      cap.spread   <= next_spread;
    end
  end

  a_cap_rate_min: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    refresh_i |=> cap.rate <= LOCAL_RATE) else $error("reported rate above local");
  a_cap_lanes_min: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    refresh_i && ds_present_i |=> cap.lanes <= $past(ds_lanes_ok)) else $error("lanes above downstream");
  a_cap_rev_min: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    refresh_i && ds_present_i |=> cap.revision <= $past(ds_rev_i)) else $error("revision above downstream");
endmodule : rlsc_cap_merge
`default_nettype wire

// File: rlsc_top.sv
// Operation
// - Sink prepares for new stream attributes after repeated idle patterns.
// - Blanking during a timing change is optional; keep disturbance small.
// - Sink silences audio while the received silence flag is set.
// - Sink re-arms audio format on change of audio packets.
// - Status change drives hot plug detect low 0.5 to 1 ms, then high.
// - Branch without local sink forwards capability data accesses downstream.
// - With several downstream ports, forward capability accesses to port 0.
// - Repeater supports four lanes on receive and downstream ports.
// - Downstream link copies upstream lane count, rate and spread.
// - Once both links are configured, pass every symbol through.
// - Revision register: minor 3:0, major 7:4, lowest common revision.
// - Rate field 4:0, only 06h and 0Ah valid, bits 7:5 zero.
// - Reported maximum rate is lowest common with downstream receiver.
// - Lane field 3:0, only 1, 2, 4 valid, bits 7:4 zero.
// - Reported maximum lanes is lowest common with downstream receiver.
// - Spread bit 0 means none, 1 means 0.5 percent; bits 7:1 zero.
// - Reported spread is lowest common with downstream receiver.
// - Converter may use fewer lanes if bandwidth suffices at reduced rate.
// - On downstream plug, re-read its capabilities and refresh own registers.
`timescale 1ns/10ps
`default_nettype none
module rlsc_top
  import rlsc_pkg::*;
#(
  parameter int         IDLE_PERIOD  = rlsc_pkg::IDLE_PERIOD_CYC,
  parameter int         HPD_LOW      = rlsc_pkg::HPD_LOW_CYC,
  parameter logic [7:0] LOCAL_REV    = 8'h10,
  parameter logic [4:0] LOCAL_RATE   = 5'h0A,
  parameter logic [3:0] LOCAL_LANES  = 4'h4,
  parameter logic       LOCAL_SPREAD = 1'b1,
  parameter logic       HAS_LOCAL_SINK = 1'b0,
  parameter int         DS_PORTS     = 2
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_B_I,
  // Received symbol stream, one symbol per clock
  input  wire logic [8:0]  SYM_I,
  input  wire logic        SYM_VALID_I,
  input  wire logic        BS_MARK_I,
  input  wire logic        VBID_MARK_I,
  input  wire logic        AUDIO_PKT_MARK_I,
  // Status change request and link configuration
  input  wire logic        STATUS_CHANGE_I,
  input  wire logic        UP_CONFIGURED_I,
  input  wire logic [3:0]  UP_LANES_I,
  input  wire logic [4:0]  UP_RATE_I,
  input  wire logic        UP_SPREAD_I,
  input  wire logic        DS_CONFIGURED_I,
  input  wire logic        DS_PRESENT_I,
  input  wire logic [7:0]  DS_REV_I,
  input  wire logic [7:0]  DS_RATE_I,
  input  wire logic [7:0]  DS_LANES_I,
  input  wire logic [7:0]  DS_SPREAD_I,
  // Capability register read port
  input  wire logic [1:0]  CAP_ADDR_I,
  input  wire logic        CAP_RD_I,
  // Upstream capability data access to forward
  input  wire logic        CAPDATA_REQ_I,
  input  wire logic [7:0]  CAPDATA_WDATA_I,
  output logic [7:0]       CAP_RDATA_O,
  output logic             CAP_RVALID_O,
  output logic             HPD_O,
  output logic             AUDIO_MUTE_O,
  output logic             VIDEO_BLANK_O,
  output logic             TIMING_REARM_O,
  output logic             AUDIO_REARM_O,
  output logic [8:0]       DS_SYM_O,
  output logic             DS_SYM_VALID_O,
  output logic [3:0]       DS_LANES_O,
  output logic [4:0]       DS_RATE_O,
  output logic             DS_SPREAD_O,
  output logic [DS_PORTS-1:0] CAPDATA_FWD_O,
  output logic [7:0]       CAPDATA_FWD_DATA_O
);
  import rlsc_pkg::*;

  localparam int IW = $clog2(IDLE_PERIOD + IDLE_SLACK_CYC + 1);
  localparam int HW = $clog2(HPD_LOW + 1);

  typedef enum logic [1:0] {
    RLSC_HPD_HIGH = 2'b00,
    RLSC_HPD_LOW  = 2'b01
  } rlsc_hpd_t;

  rlsc_cap_if cap_bus ();

  // Downstream presence comes from a pin: two-stage synchroniser
  logic ds_meta, ds_present, ds_prev, first_cycle;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      ds_meta     <= 1'b0;
      ds_present  <= 1'b0;
      ds_prev     <= 1'b0;
      first_cycle <= 1'b1;
    end else begin
      ds_meta     <= DS_PRESENT_I;
      ds_present  <= ds_meta;
      ds_prev     <= ds_present;
      first_cycle <= 1'b0;
    end
  end
  wire logic ds_edge = (ds_present != ds_prev) | first_cycle;

  rlsc_cap_merge #(
    .LOCAL_REV    (LOCAL_REV),
    .LOCAL_RATE   (LOCAL_RATE),
    .LOCAL_LANES  (LOCAL_LANES),
    .LOCAL_SPREAD (LOCAL_SPREAD)
  ) u_merge (
    .clk_i        (CORE_CLK_I),
    .rst_b_i      (RST_B_I),
    .refresh_i    (ds_edge),
    .ds_present_i (ds_present),
    .ds_rev_i     (DS_REV_I),
    .ds_rate_i    (DS_RATE_I),
    .ds_lanes_i   (DS_LANES_I),
    .ds_spread_i  (DS_SPREAD_I),
    .cap          (cap_bus.src)
  );

  // Register read decode; reserved upper bits read zero
  wire logic [7:0] rd_mux =
      (CAP_ADDR_I == OFS_CONFIG_REVISION) ? cap_bus.revision :
      (CAP_ADDR_I == OFS_PEAK_LANE_RATE)  ? {3'h0, cap_bus.rate} :
      (CAP_ADDR_I == OFS_PEAK_LANES)      ? {4'h0, cap_bus.lanes} :
                                            {7'h00, cap_bus.spread};
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      CAP_RDATA_O  <= 8'h00;
      CAP_RVALID_O <= 1'b0;
    end else begin
      CAP_RVALID_O <= CAP_RD_I;
      if (CAP_RD_I)
        CAP_RDATA_O <= rd_mux;
    end
  end

  // Idle pattern detection: vertical blank ID byte right after blank start
  logic          after_bs;
  logic [IW-1:0] idle_gap;
  logic [2:0]    idle_cnt;
  wire logic vbid_seen   = SYM_VALID_I & VBID_MARK_I & after_bs;
  wire logic idle_vbid   = vbid_seen & SYM_I[VBID_NOVIDEO_BIT] & SYM_I[VBID_VBLANK_BIT];
  wire logic gap_ok      = (idle_gap >= IW'(IDLE_PERIOD - IDLE_SLACK_CYC)) &&
                           (idle_gap <= IW'(IDLE_PERIOD + IDLE_SLACK_CYC));
  wire logic gap_over    = idle_gap > IW'(IDLE_PERIOD + IDLE_SLACK_CYC);
  wire logic [2:0] next_idle_cnt =
      idle_vbid ? ((idle_cnt == 3'h0 || gap_ok) ? ((idle_cnt == 3'(IDLE_REPEAT_MIN)) ? idle_cnt
                                                   : idle_cnt + 3'h1) : 3'h1) :
      (gap_over | (vbid_seen & ~SYM_I[VBID_NOVIDEO_BIT])) ? 3'h0 : idle_cnt;
  wire logic rearm_hit = idle_vbid && (idle_cnt == 3'(IDLE_REPEAT_MIN - 1)) && gap_ok;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      after_bs <= 1'b0;
      idle_gap <= '0;
      idle_cnt <= 3'h0;
    end else begin
      if (SYM_VALID_I)
        after_bs <= BS_MARK_I;
      idle_gap <= idle_vbid ? IW'(1) : (gap_over ? idle_gap : idle_gap + IW'(1));
      idle_cnt <= next_idle_cnt;
    end
  end

  // Timing re-arm pulse; blank output from the re-arm onwards, released on real video
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      TIMING_REARM_O <= 1'b0;
      VIDEO_BLANK_O  <= 1'b1;
    end else begin
      TIMING_REARM_O <= rearm_hit;
      if (rearm_hit)
        VIDEO_BLANK_O <= 1'b1;
      else if (vbid_seen && !SYM_I[VBID_NOVIDEO_BIT])
        VIDEO_BLANK_O <= 1'b0;
    end
  end

  // Audio silence follows the received flag; audio packets re-arm the format while audio is muted
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      AUDIO_MUTE_O  <= 1'b1;
      AUDIO_REARM_O <= 1'b0;
    end else begin
      if (vbid_seen)
        AUDIO_MUTE_O <= SYM_I[VBID_SILENCE_BIT];
      AUDIO_REARM_O <= SYM_VALID_I & AUDIO_PKT_MARK_I & AUDIO_MUTE_O;
    end
  end

  // Hot plug detect low pulse on status change or downstream change
  rlsc_hpd_t     hpd_state;
  logic [HW-1:0] hpd_cnt;
  wire logic hpd_req = STATUS_CHANGE_I | (ds_edge & ~first_cycle);
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      hpd_state <= RLSC_HPD_HIGH;
      hpd_cnt   <= '0;
      HPD_O     <= 1'b1;
    end else begin
      case (hpd_state)
        RLSC_HPD_HIGH: begin
          if (hpd_req) begin
            hpd_state <= RLSC_HPD_LOW;
            hpd_cnt   <= HW'(HPD_LOW - 1);
            HPD_O     <= 1'b0;
          end
        end
        RLSC_HPD_LOW: begin
          if (hpd_cnt == '0) begin
            hpd_state <= RLSC_HPD_HIGH;
            HPD_O     <= 1'b1;
          end else begin
            hpd_cnt <= hpd_cnt - HW'(1);
          end
        end
        default: begin
          hpd_state <= RLSC_HPD_HIGH;
          HPD_O     <= 1'b1;
        end
      endcase
    end
  end

  // Downstream link mirrors upstream; symbols pass once both are configured
  wire logic both_cfg = UP_CONFIGURED_I & DS_CONFIGURED_I;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      DS_LANES_O     <= LANES_FOUR;
      DS_RATE_O      <= RATE_LOW;
      DS_SPREAD_O    <= 1'b0;
      DS_SYM_O       <= 9'h000;
      DS_SYM_VALID_O <= 1'b0;
    end else begin
      DS_LANES_O     <= UP_LANES_I;
      DS_RATE_O      <= UP_RATE_I;
      DS_SPREAD_O    <= UP_SPREAD_I;
      DS_SYM_O       <= SYM_I;
      DS_SYM_VALID_O <= SYM_VALID_I & both_cfg;
    end
  end

  // Capability data accesses forwarded to downstream port 0
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      CAPDATA_FWD_O      <= '0;
      CAPDATA_FWD_DATA_O <= 8'h00;
    end else begin
      CAPDATA_FWD_O      <= {{(DS_PORTS-1){1'b0}}, CAPDATA_REQ_I & ~HAS_LOCAL_SINK};
      CAPDATA_FWD_DATA_O <= CAPDATA_WDATA_I;
    end
  end

  a_hpd_pulse_len: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    $fell(HPD_O) |-> hpd_cnt == HW'(HPD_LOW - 1)) else $error("hpd pulse length wrong");
  a_hpd_rise_back: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    hpd_state == RLSC_HPD_LOW && hpd_cnt == '0 |=> HPD_O) else $error("hpd not restored");
  a_mute_follow: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    vbid_seen && SYM_I[VBID_SILENCE_BIT] |=> AUDIO_MUTE_O) else $error("audio not muted");
  a_rearm_fifth: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    TIMING_REARM_O |-> idle_cnt == 3'(IDLE_REPEAT_MIN)) else $error("rearm before five idles");
  a_pass_gated: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    DS_SYM_VALID_O |-> $past(both_cfg)) else $error("symbols passed unconfigured");
  a_lanes_mirror: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    ##1 DS_LANES_O == $past(UP_LANES_I)) else $error("downstream lanes mismatch");
  a_fwd_port0: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    CAPDATA_REQ_I && !HAS_LOCAL_SINK |=> CAPDATA_FWD_O[0]) else $error("access not forwarded");
  a_rsvd_zero: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    CAP_RVALID_O && $past(CAP_ADDR_I) == OFS_SPREAD_CAPABILITY |-> CAP_RDATA_O[7:1] == 7'h00)
    else $error("reserved bits nonzero");
  c_hpd_pulse: cover property (@(posedge CORE_CLK_I) disable iff (!RST_B_I) $rose(HPD_O));
  c_rearm: cover property (@(posedge CORE_CLK_I) disable iff (!RST_B_I) TIMING_REARM_O);
  c_mute: cover property (@(posedge CORE_CLK_I) disable iff (!RST_B_I) $fell(AUDIO_MUTE_O));
endmodule : rlsc_top
`default_nettype wire

// File: rlsc_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// Upstream source: idle patterns at a fixed spacing, changing filler otherwise
module rlsc_src_model #(
  parameter int PERIOD = 600
) (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [3:0] reps_i,
  input  wire logic       novideo_i,
  input  wire logic       mute_i,
  output wire logic [8:0] sym_o,
  output wire logic       bs_o,
  output wire logic       vbid_o,
  output wire logic       busy_o
);
  logic [8:0] sym_q  = 9'h0A5;
  logic       bs_q   = 1'b0;
  logic       vbid_q = 1'b0;
  logic       busy_q = 1'b0;
  int         cnt    = 0;
  int         left   = 0;

  assign sym_o  = sym_q;
  assign bs_o   = bs_q;
  assign vbid_o = vbid_q;
  assign busy_o = busy_q;

  always @(negedge clk_i) begin
    bs_q = 1'b0;
    vbid_q = 1'b0;
    sym_q = {1'b0, ~sym_q[7:0]};
    if (go_i === 1'b1) begin
      left = reps_i;
      cnt = 0;
    end
    if (left > 0) begin
      if (cnt == 0) begin
        bs_q = 1'b1;
        sym_q = 9'h1BC;
      end
      if (cnt == 1) begin
        vbid_q = 1'b1;
        sym_q = {5'h00, novideo_i, mute_i, 1'b0, 1'b1};
      end
      cnt++;
      if (cnt == PERIOD) begin
        cnt = 0;
        left--;
      end
    end
    busy_q = (left > 0);
  end
endmodule : rlsc_src_model
`default_nettype wire

// File: test_rlsc_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_rlsc_top;
  localparam int IDLE_T = 600;
  localparam int HPD_T  = 20;
  logic       core_clk = 1'b0, rst_b = 1'b0, sym_valid = 1'b1, audio_mark = 1'b0, status_chg = 1'b0;
  logic       up_cfg = 1'b1, ds_cfg = 1'b1, up_spread = 1'b1, ds_present = 1'b0, cap_rd = 1'b0;
  logic       cd_req = 1'b0, go = 1'b0, nv = 1'b0, mute = 1'b0;
  logic [3:0] reps = 4'h0, up_lanes = 4'h4;
  logic [4:0] up_rate = 5'h0A;
  logic [1:0] cap_addr = 2'h0;
  logic [7:0] cd_wdata = 8'h00;
  logic [7:0] ds_cap [4] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [8:0] sym, ds_sym, s_prev;
  logic       bs_mark, vbid_mark, src_busy, cap_rvalid, hot_plug_detect, amute, vblank, trearm, arearm;
  logic       ds_sym_valid, ds_spread;
  logic [7:0] cap_rdata, cd_fwd_data;
  logic [3:0] ds_lanes;
  logic [4:0] ds_rate;
  logic [1:0] cd_fwd;
  int         fails = 0, n_compared = 0, n_tr = 0, n_ar = 0;
  logic [7:0] step_ds [3][4] = '{'{8'h10, 8'h06, 8'h02, 8'h00}, '{8'h10, 8'h06, 8'h02, 8'h00},
                                 '{8'h12, 8'h0A, 8'h01, 8'h01}};
  logic       step_pr [3] = '{1'b1, 1'b0, 1'b1};
  logic [7:0] step_ex [4][4] = '{'{8'h11, 8'h0A, 8'h04, 8'h01}, '{8'h10, 8'h06, 8'h02, 8'h00},
                                 '{8'h11, 8'h0A, 8'h04, 8'h01}, '{8'h11, 8'h0A, 8'h01, 8'h01}};

  always #20 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (trearm === 1'b1) n_tr++;
    if (arearm === 1'b1) n_ar++;
  end

  rlsc_src_model #(.PERIOD(IDLE_T)) src (.clk_i(core_clk), .go_i(go), .reps_i(reps), .novideo_i(nv),
    .mute_i(mute), .sym_o(sym), .bs_o(bs_mark), .vbid_o(vbid_mark), .busy_o(src_busy));

  rlsc_top #(.IDLE_PERIOD(IDLE_T), .HPD_LOW(HPD_T), .LOCAL_REV(8'h11)) dut (
    .CORE_CLK_I(core_clk), .RST_B_I(rst_b), .SYM_I(sym), .SYM_VALID_I(sym_valid), .BS_MARK_I(bs_mark),
    .VBID_MARK_I(vbid_mark), .AUDIO_PKT_MARK_I(audio_mark), .STATUS_CHANGE_I(status_chg),
    .UP_CONFIGURED_I(up_cfg), .UP_LANES_I(up_lanes), .UP_RATE_I(up_rate), .UP_SPREAD_I(up_spread),
    .DS_CONFIGURED_I(ds_cfg), .DS_PRESENT_I(ds_present), .DS_REV_I(ds_cap[0]), .DS_RATE_I(ds_cap[1]),
    .DS_LANES_I(ds_cap[2]), .DS_SPREAD_I(ds_cap[3]), .CAP_ADDR_I(cap_addr), .CAP_RD_I(cap_rd),
    .CAPDATA_REQ_I(cd_req), .CAPDATA_WDATA_I(cd_wdata), .CAP_RDATA_O(cap_rdata), .CAP_RVALID_O(cap_rvalid),
    .HPD_O(hot_plug_detect), .AUDIO_MUTE_O(amute), .VIDEO_BLANK_O(vblank), .TIMING_REARM_O(trearm),
    .AUDIO_REARM_O(arearm), .DS_SYM_O(ds_sym), .DS_SYM_VALID_O(ds_sym_valid), .DS_LANES_O(ds_lanes),
    .DS_RATE_O(ds_rate), .DS_SPREAD_O(ds_spread), .CAPDATA_FWD_O(cd_fwd), .CAPDATA_FWD_DATA_O(cd_fwd_data));

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Holds the read strobe high so that reads run back to back
  task automatic cap_check(input logic [1:0] a, input logic [7:0] exp);
    cap_addr = a;
    cap_rd = 1'b1;
    @(negedge core_clk);
    chk(9'(cap_rvalid), 9'h001);
    chk(9'(cap_rdata), 9'(exp));
  endtask : cap_check

  task automatic hpd_pulse();
    int n;
    n = 0;
    for (int i = 0; i < 10 && hot_plug_detect !== 1'b0; i++) @(negedge core_clk);
    while (hot_plug_detect === 1'b0 && n < 100) begin
      n++;
      @(negedge core_clk);
    end
    chk(9'(n), 9'(HPD_T));
  endtask : hpd_pulse

  // Gap afterwards keeps the next run from extending this idle sequence
  task automatic src_run(input logic [3:0] r, input logic v, input logic m);
    @(posedge core_clk);
    go <= 1'b1;
    reps <= r;
    nv <= v;
    mute <= m;
    @(posedge core_clk);
    go <= 1'b0;
    for (int i = 0; i < 6000 && src_busy === 1'b1; i++) @(negedge core_clk);
    cyc(400);
  endtask : src_run

  task final_report();
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  initial begin
    repeat (40000) @(posedge core_clk);
    fails++;
    final_report();
  end

  initial begin
    cyc(8);
    chk({hot_plug_detect, amute, vblank, ds_lanes, 2'b00}, {3'b111, 4'h4, 2'b00});
    chk(9'(ds_rate), 9'h006);
    rst_b = 1'b1;
    cyc(6);
    for (int i = 0; i < 4; i++) begin
      if (i > 0) begin
        ds_present = step_pr[i-1];
        for (int j = 0; j < 4; j++) ds_cap[j] = step_pr[i-1] ? step_ds[i-1][j] : ~ds_cap[j];
        hpd_pulse();
      end
      for (int j = 0; j < 4; j++) cap_check(2'(j), step_ex[i][j]);
      cap_rd = 1'b0;
      cyc(2);
    end
    fork
      hpd_pulse();
      begin
        status_chg = 1'b1;
        cyc(1);
        status_chg = 1'b0;
        cyc(5);
        status_chg = 1'b1;
        cyc(1);
        status_chg = 1'b0;
      end
    join
    up_lanes = 4'h2;
    up_rate = 5'h06;
    up_spread = 1'b0;
    cd_req = 1'b1;
    cd_wdata = 8'h5A;
    cyc(1);
    cd_req = 1'b0;
    chk(9'(cd_fwd), 9'h001);
    chk(9'(cd_fwd_data), 9'h05A);
    chk({ds_lanes, ds_rate}, {4'h2, 5'h06});
    chk(9'(ds_spread), 9'h000);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk) s_prev = sym;
      @(negedge core_clk) chk(ds_sym, s_prev);
      chk(9'(ds_sym_valid), 9'h001);
    end
    ds_cfg = 1'b0;
    cyc(2);
    chk(9'(ds_sym_valid), 9'h000);
    ds_cfg = 1'b1;
    src_run(4'h1, 1'b0, 1'b0);
    chk(9'(amute), 9'h000);
    src_run(4'h4, 1'b1, 1'b1);
    chk({amute, 8'(n_tr)}, 9'h100);
    src_run(4'h5, 1'b1, 1'b1);
    chk({vblank, 8'(n_tr)}, 9'h101);
    audio_mark = 1'b1;
    cyc(1);
    audio_mark = 1'b0;
    cyc(3);
    chk(9'(n_ar), 9'h001);
    src_run(4'h1, 1'b0, 1'b0);
    chk({amute, vblank}, 9'h000);
    audio_mark = 1'b1;
    cyc(1);
    audio_mark = 1'b0;
    cyc(3);
    chk(9'(n_ar), 9'h001);
    final_report();
  end
endmodule : test_rlsc_top
`default_nettype wire
